// ---- watchdog_config_regs.sv ----
// Watchdog control and status registers with lock, protection and sync tracking.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module watchdog_config_regs #(
  parameter int UNLOCK_CYCLES = watchdog_pkg::UNLOCK_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [watchdog_pkg::ADDR_W-1:0] address,
  input wire logic [watchdog_pkg::DATA_W-1:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [watchdog_pkg::DATA_W-1:0] read_data,
  input wire watchdog_pkg::control_byte_s watchdog_fuse_config,
  input wire logic change_protection_unlock,
  input wire logic debug_mode,
  input wire logic cpu_halt,
  input wire logic watchdog_restart_instr,
  input wire logic low_power_oscillator,
  output logic system_reset,
  output logic irq
);
  import watchdog_pkg::*;

  // The unlock window must last at least one cycle.
  if (UNLOCK_CYCLES < 1) begin : g_bad_unlock
    $error("UNLOCK_CYCLES must be at least one");
  end

  localparam int UNLOCK_W = $clog2(UNLOCK_CYCLES + 1);
  localparam logic [UNLOCK_W-1:0] UNLOCK_LOAD = UNLOCK_W'(UNLOCK_CYCLES);

  // Whole state of the register block.
  typedef struct packed {
    control_byte_s ctrl;         // Control byte as software sees it.
    logic lock;                  // Configuration lock.
    logic busy;                  // Sync pending flag.
    logic req;                   // Handshake request toward the counter.
    logic boot_done;             // Fuse already loaded.
    logic [UNLOCK_W-1:0] unlock; // Cycles left in the unlock window.
    logic [INT_W-1:0] ist;       // Sticky interrupt status.
    logic [INT_W-1:0] ien;       // Interrupt enable.
    logic [DATA_W-1:0] rdata;    // Read data, valid one cycle after a read.
    logic irq;                   // Interrupt output.
    logic sys_reset;             // System reset request.
  } regs_state_s;

  regs_state_s st_r;
  regs_state_s st_nxt;

  // Counter side of the handshake.
  logic cnt_ack;
  watchdog_event_s cnt_evt;

  // Decoded strobes and helpers.
  logic ctrl_wr;
  logic stat_wr;
  logic clr_wr;
  logic ien_wr;
  logic unlocked;
  logic sync_done;
  logic [INT_W-1:0] events;
  logic [DATA_W-1:0] status_byte;

  // Address decode; every strobe is a single cycle.
  // Decoding here keeps the write paths of the next-state process free of address compares,
  // so each write path below reads as a plain condition.
  always_comb begin
    ctrl_wr = write_strobe && (address == ADDR_CONTROL);
    stat_wr = write_strobe && (address == ADDR_STATUS);
    clr_wr = write_strobe && (address == ADDR_INT_CLEAR);
    ien_wr = write_strobe && (address == ADDR_INT_ENABLE);
    unlocked = (st_r.unlock != '0);
  end

  // Status byte image; unused bits read as zero.
  // Only the lock and the sync flag are backed by state; the rest is fixed.
  always_comb begin
    status_byte = '0;
    status_byte[LOCK_BIT] = st_r.lock;
    status_byte[BUSY_BIT] = st_r.busy;
  end

  // Next-state logic for the whole register block.
  always_comb begin
    st_nxt = st_r;
    st_nxt.sys_reset = 1'b0;
    st_nxt.rdata = '0;
    sync_done = 1'b0;

    // The unlock window opens on the key and counts down each cycle.
    // A protected write uses it up, so one key buys one write.
    if (change_protection_unlock) begin
      st_nxt.unlock = UNLOCK_LOAD;
    end else if (unlocked && (ctrl_wr || stat_wr)) begin
      st_nxt.unlock = '0;
    end else if (unlocked) begin
      st_nxt.unlock = st_r.unlock - 1'b1;
    end

    if (!st_r.boot_done) begin
      // First cycle after reset: take the fuse and ship it to the counter.
      // The fuse is sampled here rather than under reset, so reset stays constant.
      st_nxt.boot_done = 1'b1;
      st_nxt.ctrl = watchdog_fuse_config;
      st_nxt.lock = (watchdog_fuse_config.period != CODE_OFF);
      st_nxt.busy = 1'b1;
      st_nxt.req = 1'b1;
    end else begin
      // Control write. Writes while a transfer runs are dropped, because the
      // counter may be sampling the value; the flag tells software to wait.
      if (ctrl_wr && !st_r.busy) begin
        if (unlocked && !st_r.lock) begin
          st_nxt.ctrl = write_data;
        end
        st_nxt.busy = 1'b1;
        st_nxt.req = 1'b1;
      end

      // Lock write. Only a one sets it; a zero clears it in debug mode only.
      if (stat_wr && unlocked) begin
        if (write_data[LOCK_BIT]) begin
          st_nxt.lock = 1'b1;
        end else if (debug_mode) begin
          st_nxt.lock = 1'b0;
        end
      end

      // Drop the request once the counter has taken the value.
      if (st_r.req && cnt_ack) begin
        st_nxt.req = 1'b0;
      end

      // The flag falls when both handshake lines are back low, so it spans
      // the full round trip; no unlock is involved here.
      if (st_r.busy && !st_r.req && !cnt_ack) begin
        st_nxt.busy = 1'b0;
        sync_done = 1'b1;
      end
    end

    // Sticky interrupt status; a new event wins over a clear in the same cycle.
    events = '0;
    events[INT_TIMEOUT] = cnt_evt.timeout;
    events[INT_EARLY] = cnt_evt.early;
    events[INT_SYNC] = sync_done;
    for (int i = 0; i < INT_W; i++) begin
      st_nxt.ist[i] = (st_r.ist[i] && !(clr_wr && write_data[i])) || events[i];
    end
    if (ien_wr) begin
      st_nxt.ien = write_data[INT_W-1:0];
    end
    st_nxt.irq = |(st_r.ist & st_r.ien);

    // A time-out or an early restart asks for a system reset.
    st_nxt.sys_reset = cnt_evt.timeout || cnt_evt.early;

    // Read data for the next cycle only; unmapped and write-only read zero.
    if (read_strobe) begin
      unique case (address)
        ADDR_CONTROL: st_nxt.rdata = st_r.ctrl;
        ADDR_STATUS: st_nxt.rdata = status_byte;
        ADDR_INT_STATUS: st_nxt.rdata = DATA_W'(st_r.ist);
        ADDR_INT_ENABLE: st_nxt.rdata = DATA_W'(st_r.ien);
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  // State register; reset gives constants only.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from state flops.
  assign read_data = st_r.rdata;
  assign system_reset = st_r.sys_reset;
  assign irq = st_r.irq;

  // The counter runs off oscillator ticks; it only sees settings that the
  // handshake delivered, so a half-written byte never reaches it.
  // The counter keeps its own copy of the settings, so a write that is
  // refused here can never disturb a running period.
  watchdog_counter #(
    .CNT_W(COUNT_W)
  ) watchdog_counter_inst (
    .clk(clk),
    .reset_n(reset_n),
    .tick(low_power_oscillator),
    .req(st_r.req),
    .cfg(st_r.ctrl),
    .restart(watchdog_restart_instr),
    .halt(debug_mode && cpu_halt),
    .ack(cnt_ack),
    .evt(cnt_evt)
  );

  // Locked control byte cannot change through a write.
  chk_lock_holds_ctrl: assert property (
    @(posedge clk) disable iff (!reset_n)
    st_r.boot_done && st_r.lock && ctrl_wr |=> $stable(st_r.ctrl))
    else $error("Control byte changed while locked");

  // Unlocked, protected control write lands.
  chk_ctrl_write_lands: assert property (
    @(posedge clk) disable iff (!reset_n)
    st_r.boot_done && !st_r.lock && !st_r.busy && unlocked && ctrl_wr
      |=> st_r.ctrl == $past(write_data))
    else $error("Accepted control write was lost");

  // A zero written to the lock bit outside debug mode leaves the lock unchanged.
  chk_write_zero: assert property (
    @(posedge clk) disable iff (!reset_n)
    st_r.boot_done && stat_wr && !write_data[LOCK_BIT] && !debug_mode
      |=> st_r.lock == $past(st_r.lock))
    else $error("Zero write changed the lock bit");

  // Lock stays set outside debug mode.
  chk_lock_sticky: assert property (
    @(posedge clk) disable iff (!reset_n)
    st_r.lock && !debug_mode |=> st_r.lock)
    else $error("Lock cleared outside debug mode");

  // Without an open unlock window the lock cannot be set.
  chk_lock_needs_key: assert property (
    @(posedge clk) disable iff (!reset_n)
    st_r.boot_done && !st_r.lock && !unlocked |=> !st_r.lock)
    else $error("Lock set without unlock sequence");

  // Fuse with a nonzero period locks at boot.
  chk_boot_lock: assert property (
    @(posedge clk) disable iff (!reset_n)
    !st_r.boot_done && watchdog_fuse_config.period != CODE_OFF |=> st_r.lock)
    else $error("Nonzero fuse period did not lock");

  // Control byte takes the fuse value at boot.
  chk_boot_fuse: assert property (
    @(posedge clk) disable iff (!reset_n)
    !st_r.boot_done |=> st_r.ctrl == $past(watchdog_fuse_config) && st_r.busy)
    else $error("Control byte not loaded from fuse");

  // A control write raises the flag and the request together.
  chk_busy_after_write: assert property (
    @(posedge clk) disable iff (!reset_n)
    st_r.boot_done && ctrl_wr && !st_r.busy |=> st_r.busy && st_r.req)
    else $error("Sync flag not raised by control write");

  // The flag covers the request; it falls the cycle after ack drops.
  chk_busy_spans: assert property (
    @(posedge clk) disable iff (!reset_n)
    st_r.req |-> st_r.busy)
    else $error("Request outstanding without sync flag");

  // The flag falls once the round trip is over and reports sync done at once.
  chk_busy_clears: assert property (
    @(posedge clk) disable iff (!reset_n)
    st_r.busy && !st_r.req && !cnt_ack |=> !st_r.busy && st_r.ist[INT_SYNC])
    else $error("Sync flag stayed after transfer");

  // The flag falls even when no unlock window is open.
  chk_sync_no_key: assert property (
    @(posedge clk) disable iff (!reset_n)
    st_r.boot_done && st_r.busy && !st_r.req && !cnt_ack && !unlocked |=> !st_r.busy)
    else $error("Sync flag waited for the unlock sequence");

  // A control write while a transfer runs is dropped whole.
  chk_busy_drops_write: assert property (
    @(posedge clk) disable iff (!reset_n)
    st_r.boot_done && st_r.busy && ctrl_wr |=> $stable(st_r.ctrl))
    else $error("Control byte changed during a transfer");

  // One key buys one protected write; the window closes behind it.
  chk_key_used_up: assert property (
    @(posedge clk) disable iff (!reset_n)
    unlocked && (ctrl_wr || stat_wr) && !change_protection_unlock |=> !unlocked)
    else $error("Unlock window survived a protected write");

  // Read data stand for one cycle only and read zero otherwise.
  chk_rdata_idle: assert property (
    @(posedge clk) disable iff (!reset_n)
    !read_strobe |=> read_data == '0)
    else $error("Read data stood without a read");

  // A status read returns the lock and the sync flag.
  chk_status_read: assert property (
    @(posedge clk) disable iff (!reset_n)
    read_strobe && address == ADDR_STATUS |=> read_data == $past(status_byte))
    else $error("Status read returned wrong data");

  // A control read returns the byte as held.
  chk_ctrl_read: assert property (
    @(posedge clk) disable iff (!reset_n)
    read_strobe && address == ADDR_CONTROL |=> read_data == $past(st_r.ctrl))
    else $error("Control read returned wrong data");

  // The write-only clear register reads as zero.
  chk_clear_reads_zero: assert property (
    @(posedge clk) disable iff (!reset_n)
    read_strobe && address == ADDR_INT_CLEAR |=> read_data == '0)
    else $error("Clear register did not read zero");

  // The interrupt line follows enabled status with one cycle of lag.
  chk_irq_level: assert property (
    @(posedge clk) disable iff (!reset_n)
    1'b1 |=> irq == $past(|(st_r.ist & st_r.ien)))
    else $error("Interrupt line disagrees with status");

  // A counter event is recorded even when a clear hits the same cycle.
  chk_event_sticky: assert property (
    @(posedge clk) disable iff (!reset_n)
    cnt_evt.timeout || cnt_evt.early
      |=> st_r.ist[INT_TIMEOUT] || st_r.ist[INT_EARLY])
    else $error("Watchdog event lost from status");

  // No reset request appears without a counter event before it.
  chk_sysreset_idle: assert property (
    @(posedge clk) disable iff (!reset_n)
    !(cnt_evt.timeout || cnt_evt.early) |=> !system_reset)
    else $error("System reset without a watchdog event");

  // Reset request follows a counter event by one cycle.
  chk_reset_follows: assert property (
    @(posedge clk) disable iff (!reset_n)
    cnt_evt.timeout || cnt_evt.early |=> system_reset ##1 !system_reset)
    else $error("System reset did not follow watchdog event");
endmodule
`default_nettype wire

// ---- watchdog_pkg.sv ----
// Shared constants and carrier types for the watchdog configuration block.
package watchdog_pkg;
  // Register bus geometry.
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  // Register addresses.
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_INT_CLEAR = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_INT_ENABLE = 3'h4;
  // Status byte field positions.
  localparam int LOCK_BIT = 7;
  localparam int BUSY_BIT = 0;
  // Duration codes: code 1 is 8 ticks, each step doubles, up to code 0xb.
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] CODE_MAX = 4'hb;
  localparam int BASE_SHIFT = 3;
  localparam int COUNT_W = 13;
  // Unlock sequence lasts four instructions of one clock each.
  localparam int UNLOCK_INSTR = 4;
  localparam int INSTR_CYCLES = 1;
  localparam int UNLOCK_CYCLES = UNLOCK_INSTR * INSTR_CYCLES;
  // Interrupt status bit positions.
  localparam int INT_W = 3;
  localparam int INT_TIMEOUT = 0;
  localparam int INT_EARLY = 1;
  localparam int INT_SYNC = 2;
  // Control byte layout.
  typedef struct packed {
    logic [3:0] window;
    logic [3:0] period;
  } control_byte_s;
  // Reset causes reported by the counter.
  typedef struct packed {
    logic early;
    logic timeout;
  } watchdog_event_s;
endpackage

// ---- watchdog_counter.sv ----
// Watchdog counter that runs on oscillator ticks and takes new settings by handshake.
`timescale 1ns/1ps
`default_nettype none
module watchdog_counter #(
  parameter int CNT_W = watchdog_pkg::COUNT_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic req,
  input wire watchdog_pkg::control_byte_s cfg,
  input wire logic restart,
  input wire logic halt,
  output logic ack,
  output watchdog_pkg::watchdog_event_s evt
);
  import watchdog_pkg::*;

  // The longest duration must fit the counter.
  if (CNT_W < int'(CODE_MAX) + BASE_SHIFT - 1) begin : g_bad_width
    $error("CNT_W too small for the longest duration");
  end

  // Whole state of the counter.
  typedef struct packed {
    control_byte_s cfg;
    logic ack;
    logic [CNT_W-1:0] count;
    logic open_ph;
    logic armed;
    logic restart_pend;
    watchdog_event_s evt;
  } cnt_state_s;

  cnt_state_s st_r;
  cnt_state_s st_nxt;
  logic win_on;

  // Last count index of a duration; reserved codes behave as the longest one.
  function automatic logic [CNT_W-1:0] span(input logic [3:0] code);
    logic [3:0] c;
    c = (code > CODE_MAX) ? CODE_MAX : code;
    span = CNT_W'((1 << (int'(c) + BASE_SHIFT - 1)) - 1);
  endfunction

  // Next state: settings only move on a tick, as they would in the slow domain.
  always_comb begin
    st_nxt = st_r;
    st_nxt.evt = '0;
    win_on = (st_r.cfg.window != CODE_OFF) && st_r.armed;
    if (tick) begin
      // Four-phase handshake: take the value when asked, drop ack after.
      if (req && !st_r.ack) begin
        st_nxt.cfg = cfg;
        st_nxt.ack = 1'b1;
        // A newly enabled window waits for the first restart.
        if (st_r.cfg.window == CODE_OFF && cfg.window != CODE_OFF) begin
          st_nxt.armed = 1'b0;
        end
      end else if (!req && st_r.ack) begin
        st_nxt.ack = 1'b0;
      end
      if (halt) begin
        // A halted CPU resets the count and skips the next closed window.
        st_nxt.count = '0;
        st_nxt.open_ph = 1'b0;
        st_nxt.armed = 1'b0;
        st_nxt.restart_pend = 1'b0;
      end else if (st_r.cfg.period == CODE_OFF) begin
        st_nxt.count = '0;
        st_nxt.open_ph = 1'b0;
        st_nxt.restart_pend = 1'b0;
      end else if (st_r.restart_pend) begin
        // Every restart begins a new period.
        st_nxt.restart_pend = 1'b0;
        st_nxt.count = '0;
        st_nxt.open_ph = 1'b0;
        st_nxt.armed = 1'b1;
        st_nxt.evt.early = win_on && !st_r.open_ph;
      end else if (win_on && !st_r.open_ph) begin
        // Closed window, then the open window follows.
        if (st_r.count == span(st_r.cfg.window)) begin
          st_nxt.count = '0;
          st_nxt.open_ph = 1'b1;
        end else begin
          st_nxt.count = st_r.count + 1'b1;
        end
      end else if (st_r.count == span(st_r.cfg.period)) begin
        st_nxt.evt.timeout = 1'b1;
        st_nxt.count = '0;
        st_nxt.open_ph = 1'b0;
      end else begin
        st_nxt.count = st_r.count + 1'b1;
      end
    end
    // A restart in the cycle that consumes the previous one is kept.
    if (restart) begin
      st_nxt.restart_pend = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ack = st_r.ack;
  assign evt = st_r.evt;

  chk_early_restart: assert property (
    @(posedge clk) disable iff (!reset_n)
    tick && !halt && st_r.cfg.period != CODE_OFF && st_r.restart_pend && st_r.armed
      && st_r.cfg.window != CODE_OFF && !st_r.open_ph |=> st_r.evt.early)
    else $error("Restart in closed window gave no reset");

  chk_timeout_fires: assert property (
    @(posedge clk) disable iff (!reset_n)
    tick && !halt && st_r.cfg.period != CODE_OFF && !st_r.restart_pend
      && !(win_on && !st_r.open_ph) && st_r.count == span(st_r.cfg.period)
      |=> st_r.evt.timeout && st_r.count == '0)
    else $error("Time-out did not reset the system");

  chk_restart_clears: assert property (
    @(posedge clk) disable iff (!reset_n)
    tick && !halt && st_r.cfg.period != CODE_OFF && st_r.restart_pend
      |=> st_r.count == '0 && !st_r.evt.timeout)
    else $error("Restart did not begin a new period");
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking testbench for the watchdog configuration and status registers.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import watchdog_pkg::*;
  logic clk; // Peripheral clock, 25 MHz.
  logic reset_n; // Active low reset.
  logic [ADDR_W-1:0] address; // Register address.
  logic [DATA_W-1:0] write_data; // Register write data.
  logic write_strobe; // One-cycle write request.
  logic read_strobe; // One-cycle read request.
  logic [DATA_W-1:0] read_data; // Read answer, one cycle after the strobe.
  control_byte_s watchdog_fuse_config; // Fuse value loaded at boot.
  logic change_protection_unlock; // Key accepted pulse.
  logic debug_mode; // Debug mode level.
  logic cpu_halt; // Halt request, held low in every test.
  logic watchdog_restart_instr; // Restart pulse.
  logic low_power_oscillator = 1'b0; // Watchdog tick enable.
  logic system_reset; // Reset pulse from the counter.
  logic irq; // Level interrupt.
  int err_count; // Mismatches seen.
  int samples_checked; // Comparisons made.
  int rst_seen = 0; // System reset pulses seen so far.
  int tick_div = 0; // Divider that paces the watchdog ticks.
  logic [DATA_W-1:0] d; // Last value read.

  watchdog_config_regs #(.UNLOCK_CYCLES(UNLOCK_CYCLES)) watchdog_config_regs_inst (
    .clk(clk), .reset_n(reset_n), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .watchdog_fuse_config(watchdog_fuse_config),
    .change_protection_unlock(change_protection_unlock), .debug_mode(debug_mode),
    .cpu_halt(cpu_halt), .watchdog_restart_instr(watchdog_restart_instr),
    .low_power_oscillator(low_power_oscillator), .system_reset(system_reset), .irq(irq)
  );

  // Free running clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // One tick every four clocks keeps the long counts short while still slower than clk.
  always @(posedge clk) begin
    tick_div <= (tick_div == 3) ? 0 : tick_div + 1;
    low_power_oscillator <= (tick_div == 3);
    if (system_reset === 1'b1) begin
      rst_seen <= rst_seen + 1;
    end
  end

  // Compares one value and counts the outcome.
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // A wait that runs out of cycles is a failure and closes the run.
  task automatic timeout();
    err_count++;
    $display("[ERR] t=%0t wait limit seen=%h expected=%h", $time, 8'h00, 8'h01);
    stop_test();
  endtask

  // One-cycle register write.
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    address <= a;
    write_data <= v;
    write_strobe <= 1'b1;
    @(posedge clk);
    write_strobe <= 1'b0;
  endtask

  // One-cycle register read; the answer is sampled mid-cycle after the strobe.
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clk);
    read_strobe <= 1'b0;
    @(negedge clk);
    v = read_data;
  endtask

  // Key pulse followed by the protected write two cycles later.
  task automatic prot_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    change_protection_unlock <= 1'b1;
    @(posedge clk);
    change_protection_unlock <= 1'b0;
    wr_reg(a, v);
  endtask

  // Polls the status byte until the sync pending flag drops.
  task automatic wait_idle();
    logic [DATA_W-1:0] v;
    for (int i = 0; i < 100; i++) begin
      rd_reg(ADDR_STATUS, v);
      if (v[BUSY_BIT] === 1'b0) begin
        return;
      end
    end
    timeout();
  endtask

  // Waits for the next system reset pulse.
  task automatic wait_sysrst(input int max);
    int n;
    n = rst_seen;
    for (int i = 0; i < max; i++) begin
      @(negedge clk);
      if (rst_seen != n) begin
        return;
      end
    end
    timeout();
  endtask

  // One restart pulse.
  task automatic kick();
    @(posedge clk);
    watchdog_restart_instr <= 1'b1;
    @(posedge clk);
    watchdog_restart_instr <= 1'b0;
  endtask

  // Resets the block with the given fuse value and waits out the boot cycle.
  task automatic boot(input logic [DATA_W-1:0] fuse);
    @(posedge clk);
    reset_n <= 1'b0;
    watchdog_fuse_config <= fuse;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    wait_idle();
  endtask

  // Main sequence.
  initial begin
    int n;
    reset_n = 1'b0;
    address = '0;
    write_data = '0;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    watchdog_fuse_config = 8'h00;
    change_protection_unlock = 1'b0;
    debug_mode = 1'b0;
    cpu_halt = 1'b0;
    watchdog_restart_instr = 1'b0;
    err_count = 0;
    samples_checked = 0;
    boot(8'h00);
    rd_reg(ADDR_STATUS, d);
    check(d, 8'h00);
    rd_reg(ADDR_CONTROL, d);
    check(d, 8'h00);
    $display("test boot_zero_fuse done");
    // Writes without the key leave the control byte alone.
    wr_reg(ADDR_CONTROL, 8'h3c);
    wait_idle();
    rd_reg(ADDR_CONTROL, d);
    check(d, 8'h00);
    prot_wr(ADDR_CONTROL, 8'h30);
    rd_reg(ADDR_STATUS, d);
    check(d, 8'h01);
    wait_idle();
    rd_reg(ADDR_CONTROL, d);
    check(d, 8'h30);
    rd_reg(ADDR_STATUS, d);
    check(d, 8'h00);
    $display("test protected_control done");
    // Lock handling: key needed, set only, clear only in debug mode.
    wr_reg(ADDR_STATUS, 8'h81);
    rd_reg(ADDR_STATUS, d);
    check(d, 8'h00);
    prot_wr(ADDR_STATUS, 8'h80);
    rd_reg(ADDR_STATUS, d);
    check(d, 8'h80);
    prot_wr(ADDR_CONTROL, 8'h05);
    wait_idle();
    rd_reg(ADDR_CONTROL, d);
    check(d, 8'h30);
    prot_wr(ADDR_STATUS, 8'h00);
    rd_reg(ADDR_STATUS, d);
    check(d, 8'h80);
    @(posedge clk);
    debug_mode <= 1'b1;
    prot_wr(ADDR_STATUS, 8'h00);
    rd_reg(ADDR_STATUS, d);
    check(d, 8'h00);
    @(posedge clk);
    debug_mode <= 1'b0;
    $display("test lock done");
    // Sync done interrupt: raise, clear.
    wr_reg(ADDR_INT_ENABLE, 8'h04);
    repeat (3) @(negedge clk);
    check({7'h00, irq}, 8'h01);
    rd_reg(ADDR_INT_STATUS, d);
    check(d & 8'h04, 8'h04);
    wr_reg(ADDR_INT_CLEAR, 8'h07);
    rd_reg(ADDR_INT_STATUS, d);
    check(d, 8'h00);
    rd_reg(ADDR_INT_CLEAR, d);
    check(d, 8'h00);
    check({7'h00, irq}, 8'h00);
    $display("test sync_interrupt done");
    // Shortest period with no restart ends in a reset; masked, then enabled.
    prot_wr(ADDR_CONTROL, 8'h01);
    wait_idle();
    wr_reg(ADDR_INT_ENABLE, 8'h00);
    wr_reg(ADDR_INT_CLEAR, 8'h07);
    wait_sysrst(200);
    repeat (3) @(negedge clk);
    check({7'h00, irq}, 8'h00);
    rd_reg(ADDR_INT_STATUS, d);
    check(d & 8'h01, 8'h01);
    wr_reg(ADDR_INT_ENABLE, 8'h01);
    repeat (3) @(negedge clk);
    check({7'h00, irq}, 8'h01);
    wr_reg(ADDR_INT_ENABLE, 8'h00);
    // Restarting every four ticks keeps the eight-tick period from running out.
    n = rst_seen;
    repeat (20) begin
      kick();
      repeat (14) @(posedge clk);
    end
    check({7'h00, rst_seen != n}, 8'h00);
    $display("test timeout done");
    // Window mode: a second restart inside the closed window resets.
    prot_wr(ADDR_CONTROL, 8'h11);
    wait_idle();
    kick();
    wr_reg(ADDR_INT_CLEAR, 8'h07);
    kick();
    wait_sysrst(200);
    rd_reg(ADDR_INT_STATUS, d);
    check(d & 8'h02, 8'h02);
    $display("test window done");
    // Nonzero fuse period: control from the fuse and lock set at boot.
    boot(8'h25);
    rd_reg(ADDR_CONTROL, d);
    check(d, 8'h25);
    rd_reg(ADDR_STATUS, d);
    check(d, 8'h80);
    rd_reg(3'h5, d);
    check(d, 8'h00);
    $display("test fuse_boot done");
    stop_test();
  end
endmodule
`default_nettype wire
